// file: src/fse_pkg.sv
// shared constants and types for the frame security engine control block
// ==========================================================================
// Overview of operation
// RULE1: a secured frame can be encrypted then sent from normal, slot one, slot two or beacon.
// RULE2: transmit keys sit at 0x280, 0x290, and 0x2A0 shared by slot two and beacon.
// RULE3: host loads the receive key at 0x2B0-0x2BF; receive decryption uses it.
// RULE4: suite codes: 000 none, 001 counter, 010-100 CCM, 101-111 CBC-MAC.
// RULE5: suite fields at 0x2C[2:0], 0x37[2:0], 0x37[5:3], 0x2D[6:4].
// RULE6: setting secure enable and trigger in a control register encrypts then sends.
// RULE7: normal send done raises flag 0x31[0]; 0x24[0] is 0 ok, 1 failed.
// RULE8: normal retry count of latest send shows in 0x24[7:6].
// RULE9: 0x24[5] set when a failed send was caused by a busy channel.
// RULE10: slot send done raises 0x31[1] or [2]; status 1 ok, 0 failed.
// RULE11: slot retry count shows in bits 7:6 of that slot's control register.
// RULE12: 0x24[3] or [4] set when a slot send lacked time in the slot.
// RULE13: secured received frame raises 0x31[4] and waits for the host's choice.
// RULE14: host writing 0x2C[7] skips decryption and leaves the frame encrypted.
// RULE15: receive suite is programmed in 0x2C[5:3] with the common encoding.
// RULE16: 0x2C[6] starts receive decryption; completion raises 0x31[3].
// RULE17: after receive decryption 0x30[2] is 0 for no error, 1 for error.
// RULE18: writing 1 to 0x0D[0] flushes the receive buffer.
// RULE19: upper-layer header length is 5 bits, so headers stay within 31 octets.
// RULE20: host loads a 13-byte nonce at 0x240-0x24C used for upper-layer work.
// RULE21: upper-layer encryption uses the normal key at 0x280 and normal suite.
// RULE22: with 0x37[6] a secure normal trigger encrypts in place, flag 0x31[0], status 0.
// RULE23: with 0x37[7] a normal trigger decrypts in place, completion as encryption.
// RULE24: upper-layer decryption sets 0x30[6] on integrity mismatch; writing 1 clears it.
// RULE25: one cipher operation at a time; later requests wait until it completes.
// RULE26: host avoids pending slot two and beacon secure sends needing different keys.
package fse_pkg;
  // ========================================================================
  // register map
  localparam logic [9:0] A_RX_FLUSH = 10'h00D, A_BCN_CTL = 10'h01A, A_TXN_CTL = 10'h01B;
  localparam logic [9:0] A_G1_CTL = 10'h01C, A_G2_CTL = 10'h01D, A_TX_STAT = 10'h024;
  localparam logic [9:0] A_SEC0 = 10'h02C, A_SEC1 = 10'h02D, A_RX_STAT = 10'h030;
  localparam logic [9:0] A_INT_FLAGS = 10'h031, A_SEC2 = 10'h037;
  localparam logic [9:0] A_NONCE_FIRST = 10'h240, A_NONCE_LAST = 10'h24C;
  localparam logic [3:0] A_KEY_PAGE = 4'hA; // 0x280..0x2BF share bits 9:6
  // key memory byte index of each 16-byte key
  localparam logic [5:0] KEY_NORMAL = 6'h00, KEY_SLOT_ONE = 6'h10, KEY_SHARED = 6'h20, KEY_RECEIVE = 6'h30;
  localparam int unsigned KEY_BYTES = 16, NONCE_BYTES = 13, KEY_MEM_BYTES = 64;
  // ========================================================================
  // field positions
  localparam int unsigned B_TRIG = 0, B_SECEN = 1, B_RETRY = 6, B_FLUSH = 0;
  localparam int unsigned B_N_RES = 0, B_G1_RES = 1, B_G2_RES = 2, B_G1_NT = 3, B_G2_NT = 4, B_CCA = 5;
  localparam int unsigned B_SKIP = 7, B_GO = 6, B_RX_SUITE = 3, B_N_SUITE = 0, B_BCN_SUITE = 4;
  localparam int unsigned B_G1_SUITE = 0, B_G2_SUITE = 3, B_UP_ENC = 6, B_UP_DEC = 7;
  localparam int unsigned B_DEC_ERR = 2, B_UP_ERR = 6;
  localparam int unsigned F_NORMAL = 0, F_G1 = 1, F_G2 = 2, F_RX = 3, F_SEC = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] HDR_LEN_MASK = 5'h1F; // header length field is 5 bits wide
  localparam int unsigned JOB_FIFO_DEPTH = 8;
  // buffer selects toward the radio and cipher
  localparam logic [1:0] BUF_NORMAL = 2'h0, BUF_G1 = 2'h1, BUF_G2 = 2'h2, BUF_BCN = 2'h3;
  // ========================================================================
  // types
  typedef enum logic [2:0] {
    SUITE_NONE = 3'h0, SUITE_CTR = 3'h1, SUITE_CCM128 = 3'h2, SUITE_CCM64 = 3'h3,
    SUITE_CCM32 = 3'h4, SUITE_MAC128 = 3'h5, SUITE_MAC64 = 3'h6, SUITE_MAC32 = 3'h7
  } fse_suite_t;
  typedef enum logic [2:0] {
    JOB_TXN = 3'h0, JOB_G1 = 3'h1, JOB_G2 = 3'h2, JOB_BCN = 3'h3,
    JOB_RXD = 3'h4, JOB_UPE = 3'h5, JOB_UPD = 3'h6
  } fse_job_code_t;
  typedef struct packed {
    logic secure;
    fse_job_code_t code;
  } fse_job_t;
  typedef struct packed {
    logic decrypt;
    logic upper;
    logic [4:0] hdr_mask;
    fse_suite_t suite;
    logic [1:0] buf_sel;
    logic [127:0] key;
    logic [103:0] nonce;
  } fse_eng_req_t;
  typedef struct packed {
    logic ok;
    logic [1:0] retries;
    logic cca_fail;
    logic no_time;
  } fse_tx_rep_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_CIPHER = 2'b01, ST_SEND = 2'b10
  } fse_state_t;
endpackage

// file: src/fse_fifo.sv
// job queue fifo with valid/ready on both sides
`timescale 1ns/1ps
module fse_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] cnt;
  } fse_fifo_st_t;
  fse_fifo_st_t s_q, s_d;
  logic push, pop;

  // refuse shapes the pointer logic cannot serve
  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_shape
    $error("fse_fifo needs WIDTH >= 1 and DEPTH >= 2");
  end

  // honest full and empty from the occupancy count
  assign in_ready = (s_q.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers wrap at DEPTH so any depth works, not only powers of two
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : s_q.wr + PW'(1);
    end
    if (pop) begin
      s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : s_q.rd + PW'(1);
    end
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule

// file: src/fse_ctl.sv
// register file, job arbitration and sequencing of the frame security engine
`timescale 1ns/1ps
module fse_ctl
  import fse_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = fse_pkg::JOB_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_secured,
  output logic rx_flush,
  output logic eng_start,
  output fse_pkg::fse_eng_req_t eng_req,
  input wire logic eng_done,
  input wire logic eng_err,
  output logic tx_go,
  output logic [1:0] tx_buf,
  input wire logic tx_done,
  input wire fse_pkg::fse_tx_rep_t tx_rep
);
  import fse_pkg::*;

  typedef struct packed {
    logic [KEY_MEM_BYTES-1:0][7:0] key;
    logic [NONCE_BYTES-1:0][7:0] nonce;
    logic [7:0] flush_ctl;
    logic [1:0] bcn_ctl;
    logic [4:0] txn_ctl;
    logic [7:0] g1_ctl;
    logic [7:0] g2_ctl;
    logic [7:0] tx_stat;
    logic [7:0] sec0;
    logic [7:0] sec1;
    logic [7:0] sec2;
    logic dec_err;
    logic up_err;
    logic [4:0] flags;
    logic rx_pend;
    fse_state_t st;
    fse_job_t job;
    logic eng_start;
    fse_eng_req_t eng_req;
    logic tx_go;
    logic [1:0] tx_buf;
    logic flush;
    logic [7:0] rdata;
  } fse_ctl_st_t;

  fse_ctl_st_t s_q, s_d;
  fse_job_t push_job, pop_job;
  logic push_valid, push_ready, pop_valid, pop_ready;
  logic wr_key, wr_nonce;

  // refuse a queue too shallow to hold a waiting job
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fse_ctl needs FIFO_DEPTH >= 2");
  end

  // 16-byte key starting at a key memory index, lowest address in the low byte
  function automatic logic [127:0] key_at(input fse_ctl_st_t s, input logic [5:0] base);
    logic [127:0] k;
    k = '0;
    for (int i = 0; i < KEY_BYTES; i++) begin
      k[8*i +: 8] = s.key[6'(base + 6'(i))];
    end
    return k;
  endfunction

  // suite field and key location that serve each job
  function automatic fse_suite_t suite_of(input fse_ctl_st_t s, input fse_job_code_t c);
    case (c)
      JOB_G1: suite_of = fse_suite_t'(s.sec2[B_G1_SUITE +: 3]); // RULE5
      JOB_G2: suite_of = fse_suite_t'(s.sec2[B_G2_SUITE +: 3]); // RULE5
      JOB_BCN: suite_of = fse_suite_t'(s.sec1[B_BCN_SUITE +: 3]); // RULE5
      JOB_RXD: suite_of = fse_suite_t'(s.sec0[B_RX_SUITE +: 3]); // RULE15
      default: suite_of = fse_suite_t'(s.sec0[B_N_SUITE +: 3]); // RULE21
    endcase
  endfunction

  function automatic logic [5:0] key_base(input fse_job_code_t c);
    case (c)
      JOB_G1: key_base = KEY_SLOT_ONE; // RULE2
      JOB_G2, JOB_BCN: key_base = KEY_SHARED; // RULE2
      JOB_RXD: key_base = KEY_RECEIVE; // RULE3
      default: key_base = KEY_NORMAL; // RULE21
    endcase
  endfunction

  function automatic logic [1:0] buf_of(input fse_job_code_t c);
    case (c)
      JOB_G1: buf_of = BUF_G1;
      JOB_G2: buf_of = BUF_G2;
      JOB_BCN: buf_of = BUF_BCN;
      default: buf_of = BUF_NORMAL;
    endcase
  endfunction

  // ========================================================================
  // job arbitration: a trigger stays set until its job is queued
  always_comb begin
    push_valid = 1'b1;
    push_job = '{secure: 1'b1, code: JOB_RXD};
    if (s_q.sec0[B_GO]) begin
      push_job = '{secure: 1'b1, code: JOB_RXD}; // RULE16
    end else if (s_q.txn_ctl[B_TRIG] && s_q.sec2[B_UP_DEC]) begin
      push_job = '{secure: 1'b1, code: JOB_UPD}; // RULE23
    end else if (s_q.txn_ctl[B_TRIG] && s_q.sec2[B_UP_ENC] && s_q.txn_ctl[B_SECEN]) begin
      push_job = '{secure: 1'b1, code: JOB_UPE}; // RULE22
    end else if (s_q.txn_ctl[B_TRIG]) begin
      push_job = '{secure: s_q.txn_ctl[B_SECEN], code: JOB_TXN}; // RULE6
    end else if (s_q.g1_ctl[B_TRIG]) begin
      push_job = '{secure: s_q.g1_ctl[B_SECEN], code: JOB_G1}; // RULE1
    end else if (s_q.g2_ctl[B_TRIG]) begin
      push_job = '{secure: s_q.g2_ctl[B_SECEN], code: JOB_G2}; // RULE1
    end else if (s_q.bcn_ctl[B_TRIG]) begin
      push_job = '{secure: s_q.bcn_ctl[B_SECEN], code: JOB_BCN}; // RULE1
    end else begin
      push_valid = 1'b0;
    end
  end

  // the queue holds waiting jobs while the single engine is busy
  fse_fifo #(
    .WIDTH($bits(fse_job_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_jobs (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_job),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_job)
  );
  assign pop_ready = (s_q.st == ST_IDLE); // RULE25

  assign wr_key = reg_wr && (reg_addr[9:6] == A_KEY_PAGE);
  assign wr_nonce = reg_wr && (reg_addr >= A_NONCE_FIRST) && (reg_addr <= A_NONCE_LAST);

  // ========================================================================
  // next state: register writes, sequencing, completion reporting
  always_comb begin
    logic done_now;
    fse_job_code_t c;
    s_d = s_q;
    done_now = 1'b0;
    c = s_q.job.code;
    s_d.eng_start = 1'b0;
    s_d.tx_go = 1'b0;
    s_d.flush = 1'b0;
    // self-clearing bits drop before host writes, so a fresh write in the same cycle wins
    if (s_q.sec0[B_SKIP]) begin
      s_d.sec0[B_SKIP] = 1'b0;
    end
    // a queued job releases its trigger
    if (push_valid && push_ready) begin
      case (push_job.code)
        JOB_RXD: s_d.sec0[B_GO] = 1'b0;
        JOB_TXN, JOB_UPE, JOB_UPD: s_d.txn_ctl[B_TRIG] = 1'b0;
        JOB_G1: s_d.g1_ctl[B_TRIG] = 1'b0;
        JOB_G2: s_d.g2_ctl[B_TRIG] = 1'b0;
        default: s_d.bcn_ctl[B_TRIG] = 1'b0;
      endcase
      if (push_job.code == JOB_RXD) begin
        s_d.rx_pend = 1'b0;
      end
    end
    // host writes
    if (wr_key) begin
      s_d.key[reg_addr[5:0]] = reg_wdata; // RULE2 RULE3
    end
    if (wr_nonce) begin
      s_d.nonce[reg_addr[3:0]] = reg_wdata; // RULE20
    end
    if (reg_wr) begin
      case (reg_addr)
        A_RX_FLUSH: begin
          s_d.flush_ctl = {reg_wdata[7:1], 1'b0};
          s_d.flush = reg_wdata[B_FLUSH]; // RULE18
        end
        A_BCN_CTL: s_d.bcn_ctl = reg_wdata[1:0];
        A_TXN_CTL: s_d.txn_ctl = reg_wdata[4:0];
        A_G1_CTL: s_d.g1_ctl[5:0] = reg_wdata[5:0];
        A_G2_CTL: s_d.g2_ctl[5:0] = reg_wdata[5:0];
        A_SEC0: begin
          s_d.sec0 = reg_wdata;
          if (reg_wdata[B_SKIP]) begin
            s_d.rx_pend = 1'b0; // RULE14
          end
        end
        A_SEC1: s_d.sec1 = reg_wdata;
        A_SEC2: s_d.sec2 = reg_wdata;
        A_RX_STAT: begin
          if (reg_wdata[B_UP_ERR]) begin
            s_d.up_err = 1'b0; // RULE24
          end
        end
        default: begin
        end
      endcase
    end
    // flags clear on read; events below are applied later and so win
    if (reg_rd && reg_addr == A_INT_FLAGS) begin
      s_d.flags = '0;
    end
    // secured frame arrival waits for the host to decide
    if (rx_secured) begin
      s_d.flags[F_SEC] = 1'b1; // RULE13
      s_d.rx_pend = 1'b1; // RULE13
    end
    // sequencer
    case (s_q.st)
      ST_IDLE: begin
        if (pop_valid) begin
          c = pop_job.code;
          s_d.job = pop_job;
          if (pop_job.secure && suite_of(s_q, c) != SUITE_NONE) begin
            s_d.st = ST_CIPHER; // RULE25
            s_d.eng_start = 1'b1;
            s_d.eng_req.decrypt = (c == JOB_RXD) || (c == JOB_UPD);
            s_d.eng_req.upper = (c == JOB_UPE) || (c == JOB_UPD);
            s_d.eng_req.hdr_mask = HDR_LEN_MASK; // RULE19
            s_d.eng_req.suite = suite_of(s_q, c); // RULE4
            s_d.eng_req.buf_sel = buf_of(c);
            s_d.eng_req.key = key_at(s_q, key_base(c)); // RULE2 RULE3 RULE21
            s_d.eng_req.nonce = s_q.nonce; // RULE20
          end else if (c <= JOB_BCN) begin
            s_d.st = ST_SEND;
            s_d.tx_go = 1'b1;
            s_d.tx_buf = buf_of(c);
          end else begin
            done_now = 1'b1;
          end
        end
      end
      ST_CIPHER: begin
        if (eng_done) begin
          if (c <= JOB_BCN) begin
            s_d.st = ST_SEND; // RULE6
            s_d.tx_go = 1'b1;
            s_d.tx_buf = buf_of(c);
          end else begin
            done_now = 1'b1;
          end
        end
      end
      ST_SEND: begin
        if (tx_done) begin
          s_d.st = ST_IDLE;
          case (c)
            JOB_TXN: begin
              s_d.flags[F_NORMAL] = 1'b1; // RULE7
              s_d.tx_stat[B_N_RES] = !tx_rep.ok; // RULE7
              s_d.tx_stat[B_RETRY +: 2] = tx_rep.retries; // RULE8
            end
            JOB_G1: begin
              s_d.flags[F_G1] = 1'b1; // RULE10
              s_d.tx_stat[B_G1_RES] = tx_rep.ok; // RULE10
              s_d.tx_stat[B_G1_NT] = !tx_rep.ok && tx_rep.no_time; // RULE12
              s_d.g1_ctl[B_RETRY +: 2] = tx_rep.retries; // RULE11
            end
            JOB_G2: begin
              s_d.flags[F_G2] = 1'b1; // RULE10
              s_d.tx_stat[B_G2_RES] = tx_rep.ok; // RULE10
              s_d.tx_stat[B_G2_NT] = !tx_rep.ok && tx_rep.no_time; // RULE12
              s_d.g2_ctl[B_RETRY +: 2] = tx_rep.retries; // RULE11
            end
            default: begin
            end
          endcase
          s_d.tx_stat[B_CCA] = !tx_rep.ok && tx_rep.cca_fail; // RULE9
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // in-place and receive jobs finish without the radio
    if (done_now) begin
      s_d.st = ST_IDLE;
      if (c == JOB_RXD) begin
        s_d.flags[F_RX] = 1'b1; // RULE16
        s_d.dec_err = (s_q.st == ST_CIPHER) && eng_err; // RULE17
      end else begin
        s_d.flags[F_NORMAL] = 1'b1; // RULE22 RULE23
        s_d.tx_stat[B_N_RES] = 1'b0; // RULE22 RULE23
        if (c == JOB_UPD && s_q.st == ST_CIPHER && eng_err) begin
          s_d.up_err = 1'b1; // RULE24
        end
      end
    end
    // read data, registered; unmapped and write-only space reads zero
    s_d.rdata = RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        A_RX_FLUSH: s_d.rdata = s_q.flush_ctl;
        A_BCN_CTL: s_d.rdata = {6'h00, s_q.bcn_ctl};
        A_TXN_CTL: s_d.rdata = {3'h0, s_q.txn_ctl};
        A_G1_CTL: s_d.rdata = s_q.g1_ctl;
        A_G2_CTL: s_d.rdata = s_q.g2_ctl;
        A_TX_STAT: s_d.rdata = s_q.tx_stat;
        A_SEC0: s_d.rdata = s_q.sec0;
        A_SEC1: s_d.rdata = s_q.sec1;
        A_SEC2: s_d.rdata = s_q.sec2;
        A_RX_STAT: s_d.rdata = {1'b0, s_q.up_err, 3'h0, s_q.dec_err, 2'h0};
        A_INT_FLAGS: s_d.rdata = {3'h0, s_q.flags};
        default: begin
          if (reg_addr[9:6] == A_KEY_PAGE) begin
            s_d.rdata = s_q.key[reg_addr[5:0]];
          end else if (reg_addr >= A_NONCE_FIRST && reg_addr <= A_NONCE_LAST) begin
            s_d.rdata = s_q.nonce[reg_addr[3:0]];
          end
        end
      endcase
    end
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign rx_flush = s_q.flush;
  assign eng_start = s_q.eng_start;
  assign eng_req = s_q.eng_req;
  assign tx_go = s_q.tx_go;
  assign tx_buf = s_q.tx_buf;

  // ========================================================================
  // checks
  chk_single_engine_op: assert property (@(posedge clk) disable iff (sys_rst) // RULE25
    (ce && s_q.st != ST_IDLE) |=> !eng_start) else $error("engine started while busy");
  chk_shared_key_used: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    (eng_start && (s_q.job.code == JOB_G2 || s_q.job.code == JOB_BCN)) |->
    eng_req.key == key_at(s_q, KEY_SHARED)) else $error("slot two or beacon key wrong");
  chk_rx_key_used: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    (eng_start && s_q.job.code == JOB_RXD) |-> eng_req.key == key_at(s_q, KEY_RECEIVE) && eng_req.decrypt)
    else $error("receive key or direction wrong");
  chk_normal_result: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    (ce && s_q.st == ST_SEND && tx_done && s_q.job.code == JOB_TXN) |=>
    s_q.flags[F_NORMAL] && s_q.tx_stat[B_N_RES] == !$past(tx_rep.ok) && s_q.tx_stat[7:6] == $past(tx_rep.retries))
    else $error("normal send result wrong");
  chk_slot_polarity: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
    (ce && s_q.st == ST_SEND && tx_done && s_q.job.code == JOB_G1) |=>
    s_q.flags[F_G1] && s_q.tx_stat[B_G1_RES] == $past(tx_rep.ok)) else $error("slot one result wrong");
  chk_slot_retries: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    (ce && s_q.st == ST_SEND && tx_done && s_q.job.code == JOB_G2) |=>
    s_q.g2_ctl[7:6] == $past(tx_rep.retries)) else $error("slot two retry count wrong");
  chk_secured_wait: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    (ce && rx_secured) |=> s_q.flags[F_SEC] && s_q.rx_pend) else $error("secured frame not flagged");
  chk_rx_decrypt_done: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
    (ce && s_q.st == ST_CIPHER && eng_done && s_q.job.code == JOB_RXD) |=>
    s_q.flags[F_RX] && s_q.dec_err == $past(eng_err) && s_q.st == ST_IDLE) else $error("decrypt status wrong");
  chk_flush_pulse: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
    (ce && reg_wr && reg_addr == A_RX_FLUSH && reg_wdata[B_FLUSH]) |=> rx_flush ##1 (!rx_flush || !$past(ce)))
    else $error("flush not a single pulse");
  chk_inplace_no_send: assert property (@(posedge clk) disable iff (sys_rst) // RULE22
    (ce && s_q.st == ST_CIPHER && eng_done && s_q.job.code == JOB_UPE) |=>
    !tx_go && s_q.flags[F_NORMAL] && !s_q.tx_stat[B_N_RES]) else $error("upper encrypt sent or misreported");
  chk_upper_mic: assert property (@(posedge clk) disable iff (sys_rst) // RULE24
    (ce && s_q.st == ST_CIPHER && eng_done && eng_err && s_q.job.code == JOB_UPD) |=> s_q.up_err)
    else $error("integrity error not flagged");
  cov_rx_decrypt: cover property (@(posedge clk) disable iff (sys_rst)
    s_q.rx_pend ##[1:50] (eng_start && eng_req.decrypt));
  cov_slot_send: cover property (@(posedge clk) disable iff (sys_rst)
    (s_q.st == ST_SEND && s_q.job.code == JOB_G1 && tx_done && tx_rep.ok));
  cov_queue_full: cover property (@(posedge clk) disable iff (sys_rst) push_valid && !push_ready);
endmodule

// file: sim/fse_far.sv
// cipher engine and radio stand-in facing the control block
`timescale 1ns/1ps
module fse_far
  import fse_pkg::*;
(
  input wire logic clk,
  input wire logic eng_start,
  output logic eng_done,
  output logic eng_err,
  input wire logic tx_go,
  output logic tx_done,
  output fse_pkg::fse_tx_rep_t tx_rep,
  input wire logic err_set,
  input wire fse_pkg::fse_tx_rep_t rep_set
);
  int ec = 0;
  int tc = 0;
  initial begin
    eng_done = 0;
    tx_done = 0;
  end
  // random 1..16 cycle latency, so prompt and slow answers both occur
  always @(posedge clk) begin
    eng_done <= (ec == 1);
    eng_err <= (ec == 1) ? err_set : 1'($urandom); // junk outside the pulse
    tx_done <= (tc == 1);
    tx_rep <= (tc == 1) ? rep_set : ~rep_set;
    ec <= eng_start ? 1 + $urandom % 16 : (ec > 0 ? ec - 1 : 0);
    tc <= tx_go ? 1 + $urandom % 16 : (tc > 0 ? tc - 1 : 0);
  end
endmodule

// file: sim/fse_ctl_test.sv
// self-checking bench for the frame security control block
`timescale 1ns/1ps
module fse_ctl_test;
  import fse_pkg::*;
  logic clk = 0, sys_rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, rx_secured = 0, err_set = 0, busy = 0;
  logic [9:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, b;
  logic rx_flush, eng_start, eng_done, eng_err, tx_go, tx_done;
  logic [1:0] tx_buf;
  logic [15:0] e;
  logic [127:0] key [4];
  logic [103:0] nonce;
  logic [9:0] ca [4] = '{A_TXN_CTL, A_G1_CTL, A_G2_CTL, A_BCN_CTL};
  fse_eng_req_t eng_req, rq;
  fse_tx_rep_t tx_rep, rep_set = '0;
  int n_fail = 0, tests_run = 0, cyc = 0, fl = 0, i, bf;
  always #50 clk = ~clk;
  fse_ctl dut_u (.clk, .sys_rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .rx_secured,
    .rx_flush, .eng_start, .eng_req, .eng_done, .eng_err, .tx_go, .tx_buf, .tx_done, .tx_rep);
  fse_far far_u (.clk, .eng_start, .eng_done, .eng_err, .tx_go, .tx_done, .tx_rep, .err_set, .rep_set);
  // ==========
  // watch handovers; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    busy <= eng_start | (busy & !eng_done);
    if (eng_start) rq <= eng_req;
    if (eng_start) chk(busy, 0);
    if (rx_flush) fl <= fl + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(logic [255:0] g, logic [255:0] x);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] m, logic [7:0] x);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    @(posedge clk);
    chk(reg_rdata & m, x);
  endtask
  // wait for the radio or the cipher to finish, bounded
  task automatic wt(bit tx);
    int k;
    for (k = 0; k < 200 && !(tx ? tx_done : eng_done); k++) @(posedge clk);
    if (k == 200) n_fail++;
    repeat (3) @(posedge clk);
  endtask
  // mask and value expected in the transmit status byte
  function automatic logic [15:0] stat(int n, fse_tx_rep_t r);
    logic f = !r.ok;
    case (n)
      0: return {8'hE1, r.retries, r.cca_fail & f, 4'h0, f};
      1: return {8'h2A, 2'h0, r.cca_fail & f, 1'b0, r.no_time & f, 1'b0, r.ok, 1'b0};
      default: return {8'h34, 2'h0, r.cca_fail & f, r.no_time & f, 1'b0, r.ok, 2'h0};
    endcase
  endfunction
  initial begin
    void'($urandom(32'h5ac54482));
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    rd(A_INT_FLAGS, 8'hFF, 8'h00);
    // slot two and beacon get one shared key
    for (i = 0; i < 77; i++) begin
      b = $urandom;
      if (i < 64) key[i/16][8*(i%16)+:8] = b;
      else nonce[8*(i-64)+:8] = b;
      wr(i < 64 ? 10'(10'h280 + i) : 10'(A_NONCE_FIRST + i - 64), b);
    end
    // every suite code once, each buffer twice
    for (i = 0; i < 8; i++) begin
      bf = i % 4;
      rep_set = $urandom;
      wr(A_SEC0, 8'(i));
      wr(A_SEC2, 8'(i * 9));
      wr(A_SEC1, 8'(i * 16));
      wr(ca[bf], 8'h03);
      wt(1);
      if (i > 0) chk({rq.suite, rq.buf_sel, rq.key}, {3'(i), 2'(bf), key[bf == 3 ? 2 : bf]});
      chk(tx_buf, bf);
      rd(A_INT_FLAGS, 8'h1F, bf == 3 ? 8'h0 : 8'(1 << bf));
      e = stat(bf, rep_set);
      if (bf != 3) rd(A_TX_STAT, e[15:8], e[7:0]);
      if (bf == 1 || bf == 2) rd(ca[bf], 8'hC0, {rep_set.retries, 6'h0});
    end
    // a write while the clock enable is low must not land
    ce <= 0;
    wr(A_SEC1, 8'h5A);
    ce <= 1;
    rd(A_SEC1, 8'hFF, 8'h70);
    rx_secured <= 1;
    @(posedge clk);
    rx_secured <= 0;
    rd(A_INT_FLAGS, 8'h1F, 8'h10);
    err_set = 1;
    wr(A_SEC0, 8'h50);
    wt(0);
    chk({rq.decrypt, rq.suite, rq.key}, {4'hA, key[3]});
    rd(A_INT_FLAGS, 8'h1F, 8'h08);
    rd(A_RX_STAT, 8'h04, 8'h04);
    wr(A_RX_FLUSH, 8'h01);
    repeat (2) @(posedge clk);
    chk(fl, 1);
    rx_secured <= 1;
    @(posedge clk);
    rx_secured <= 0;
    wr(A_SEC0, 8'h82);
    repeat (5) @(posedge clk);
    rd(A_INT_FLAGS, 8'h1F, 8'h10);
    rd(A_SEC0, 8'h80, 8'h00);
    err_set = 0;
    wr(A_SEC2, 8'h40);
    wr(A_TXN_CTL, 8'h03);
    wt(0);
    chk({rq.upper, rq.decrypt, rq.hdr_mask, rq.key, rq.nonce}, {7'h5F, key[0], nonce});
    rd(A_INT_FLAGS, 8'h1F, 8'h01);
    rd(A_TX_STAT, 8'h01, 8'h00);
    err_set = 1;
    wr(A_SEC2, 8'h80);
    wr(A_TXN_CTL, 8'h01);
    wt(0);
    rd(A_INT_FLAGS, 8'h1F, 8'h01);
    rd(A_RX_STAT, 8'h40, 8'h40);
    wr(A_RX_STAT, 8'h40);
    rd(A_RX_STAT, 8'h40, 8'h00);
    // two cipher jobs queued back to back must run one after the other
    wr(A_SEC2, 8'h01);
    wr(A_G1_CTL, 8'h03);
    wr(A_TXN_CTL, 8'h03);
    wt(1);
    wt(1);
    rd(A_INT_FLAGS, 8'h1F, 8'h03);
    end_of_test();
  end
endmodule
